/* inc/csr_clk_if.sv */
`timescale 1ns/1ps
interface csr_clk_if;
  logic       osc_tick;
  logic       safeguard_en;
  logic       main_osc_off;
  logic       clk_tick;
  logic       aux_active;
  modport filt (input osc_tick, input safeguard_en, input main_osc_off,
                output clk_tick, output aux_active);
  modport ctrl (output osc_tick, output safeguard_en, output main_osc_off,
                input clk_tick, input aux_active);
endinterface : csr_clk_if

/* inc/csr_pkg.sv */
// Operation
// (R01) Safeguard filters spikes, caps internal clock
// (R02) Too-fast input edges dropped as spikes
// (R03) Safeguard enable is a static option
// (R04) Aux oscillator starts after first missing edge
// (R05) Divider bits: 00=1, 01=2, 1x=4
// (R06) Bit3 cleared at reset; bit2 low; 7:4 unused
// (R07) Software keeps RAM image for ISR writes
// (R08) Four reset causes accepted
// (R09) Active-low pin, delayed internal reset
// (R10) Pin reset in run/wait: halt, pullups, restart
// (R11) Pin reset in stop: start oscillator, pullups
// (R12) Power-on holds reset, then stabilisation delay
// (R13) Watchdog end of count resets, reinitialises watchdog
// (R14) Watchdog reset restarts like pin reset
// (R15) Low voltage holds static reset
// (R16) Internal reset sources drive pin low
// (R17) Avoid safeguard with serial or precise timing
// (R18) Oscillator-off bit stops main, aux takes over
// (R19) Aux oscillator stops when main runs
// (R20) Leave reset at vector, non-maskable mode
// (R21) Delay counter restarted by every reset source
package csr_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] CSR_DIV_CTRL_ADDR = 12'h0dc;
  localparam logic [11:0] CSR_OSC_CTRL_ADDR = 12'h0d0;
  localparam logic [11:0] CSR_STATUS_ADDR   = 12'h0d4;
  localparam logic [7:0]  CSR_DIV_RESET     = 8'h00;
  localparam int          CSR_DIV_SEL_LSB   = 0;
  localparam int          CSR_OSC_OFF_BIT   = 2;
  localparam logic [11:0] CSR_RESET_VECTOR  = 12'hffe;
  // ==========================================================
  // Timing
  localparam int CSR_CLK_MHZ          = 20;
  localparam int CSR_MIN_PERIOD_NS    = 100;
  localparam int CSR_MIN_PERIOD_CYC   = (CSR_MIN_PERIOD_NS * CSR_CLK_MHZ + 999) / 1000;
  localparam int CSR_MISS_NS          = 400;
  localparam int CSR_MISS_CYC         = (CSR_MISS_NS * CSR_CLK_MHZ) / 1000;
  localparam int CSR_STAB_CYC         = 4096;
  typedef enum logic [1:0] {CSR_DIV1, CSR_DIV2, CSR_DIV4} csr_div_t;
endpackage : csr_pkg

/* src/csr_clock_reset.sv */
`timescale 1ns/1ps
module csr_clock_reset #(
  parameter int STAB_CYC = csr_pkg::CSR_STAB_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        osc_in_tick,
  input  wire logic        safeguard_option,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire logic        power_on_det,
  input  wire logic        watchdog_timeout,
  input  wire logic        low_voltage_det,
  input  wire logic        stop_mode,
  output logic             int_clk_tick,
  output logic             aux_osc_active,
  output logic             core_reset,
  output logic             io_pullup_inputs,
  output logic             watchdog_reinit,
  output logic             main_osc_run,
  output logic             init_start,
  output logic [11:0]      init_pc,
  output logic             init_nmi_mode
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]  div_sel;
    logic        bit3;
    logic        osc_off;
    logic [1:0]  div_cnt;
    logic        tick;
    logic [15:0] stab;
    logic        in_rst;
    logic        pin_drive;
    logic        wd_reinit;
    logic        init;
    logic        ready;
    logic [31:0] rdata;
    logic        err;
  } csr_top_state_t;
  csr_top_state_t st_ff, nxt_st;

  csr_clk_if cif ();
  assign cif.osc_tick     = osc_in_tick;
  assign cif.safeguard_en = safeguard_option;
  assign cif.main_osc_off = st_ff.osc_off;

  csr_safeguard u_sg (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  function automatic logic [1:0] div_mask(input logic [1:0] sel);
    case (sel) // R05
      2'b00:   div_mask = 2'b00;
      2'b01:   div_mask = 2'b01;
      default: div_mask = 2'b11;
    endcase
  endfunction : div_mask

  logic int_src;
  logic any_src;
  logic acc;
  assign int_src = power_on_det || watchdog_timeout || low_voltage_det; // R08
  assign any_src = int_src || !reset_pin_in; // R09
  assign acc     = psel && penable && !st_ff.ready;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.tick      = 1'b0;
    nxt_st.init      = 1'b0;
    nxt_st.ready     = acc;
    nxt_st.err       = 1'b0;
    nxt_st.wd_reinit = watchdog_timeout; // R13
    nxt_st.pin_drive = int_src; // R16
    if (cif.clk_tick) begin
      nxt_st.div_cnt = st_ff.div_cnt + 2'b01;
      if ((st_ff.div_cnt & div_mask(st_ff.div_sel)) == div_mask(st_ff.div_sel)) begin
        nxt_st.tick    = 1'b1;
        nxt_st.div_cnt = 2'b00;
      end
    end
    if (any_src) begin
      nxt_st.in_rst  = 1'b1; // R10 R11 R12 R15
      nxt_st.stab    = 16'h0000; // R21
      nxt_st.osc_off = 1'b0;
      nxt_st.div_sel = 2'b00;
      nxt_st.bit3    = 1'b0; // R06
    end else if (st_ff.in_rst && cif.clk_tick) begin
      // Delay counts safeguard clock ticks, main or aux, so a stopped clock holds reset only with the safeguard off
      if (st_ff.stab == 16'(STAB_CYC - 1)) begin
        nxt_st.in_rst = 1'b0; // R14
        nxt_st.init   = 1'b1; // R20
      end else begin
        nxt_st.stab = st_ff.stab + 16'h0001;
      end
    end
    if (acc) begin
      // Reset sources win over a write landing in the same cycle
      if (paddr == csr_pkg::CSR_DIV_CTRL_ADDR) begin
        if (pwrite && !any_src) begin
          nxt_st.div_sel = pwdata[csr_pkg::CSR_DIV_SEL_LSB +: 2];
          nxt_st.bit3    = pwdata[3];
        end else begin
          nxt_st.rdata = 32'h0000_0000; // Write-only: reads zero
        end
      end else if (paddr == csr_pkg::CSR_OSC_CTRL_ADDR) begin
        if (pwrite && !any_src) begin
          nxt_st.osc_off = pwdata[csr_pkg::CSR_OSC_OFF_BIT] && safeguard_option; // R18
        end else begin
          nxt_st.rdata = {29'h0, st_ff.osc_off, 2'b00};
        end
      end else if (paddr == csr_pkg::CSR_STATUS_ADDR && !pwrite) begin
        nxt_st.rdata = {28'h0, st_ff.in_rst, cif.aux_active, st_ff.div_sel};
      end else begin
        nxt_st.err   = 1'b1;
        nxt_st.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff        <= '0;
      st_ff.in_rst <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  logic aux_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ff <= 1'b0;
    end else begin
      aux_ff <= cif.aux_active;
    end
  end

  assign pready           = st_ff.ready;
  assign prdata           = st_ff.rdata;
  assign pslverr          = st_ff.err;
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe     = st_ff.pin_drive; // R16
  assign int_clk_tick     = st_ff.tick;
  assign aux_osc_active   = aux_ff;
  assign core_reset       = st_ff.in_rst;
  assign io_pullup_inputs = st_ff.in_rst; // R10 R11
  assign watchdog_reinit  = st_ff.wd_reinit;
  assign main_osc_run     = !st_ff.osc_off;
  assign init_start       = st_ff.init;
  assign init_pc          = csr_pkg::CSR_RESET_VECTOR; // R20
  assign init_nmi_mode    = st_ff.in_rst || st_ff.init;

  // ==========================================================
  // Checks
  a_src_holds_rst: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> core_reset && st_ff.stab == 16'h0000) // R21
    else $error("reset source did not restart delay");
  a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
    int_src |=> reset_pin_oe) // R16
    else $error("reset pin not driven low");
  a_wd_reinit: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_timeout |=> watchdog_reinit && core_reset) // R13
    else $error("watchdog reset missing");
  a_init_after: assert property (@(posedge pclk) disable iff (!presetn)
    init_start |-> $past(core_reset) && !core_reset) // R14
    else $error("init without reset release");
  a_lv_static: assert property (@(posedge pclk) disable iff (!presetn)
    low_voltage_det [*2] |-> core_reset) // R15
    else $error("low voltage not holding reset");
  a_div_reset: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> st_ff.div_sel == 2'b00 && !st_ff.bit3) // R06
    else $error("divider not cleared");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready) // APB access answered in the next cycle
    else $error("apb not answered");
  a_div1_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.clk_tick && st_ff.div_sel == 2'b00 && !any_src) |=> int_clk_tick) // R05
    else $error("divide by one lost tick");
  a_osc_restart: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> main_osc_run) // R10
    else $error("main oscillator not restarted");
endmodule : csr_clock_reset

/* src/csr_safeguard.sv */
`timescale 1ns/1ps
module csr_safeguard #(
  parameter int MIN_GAP  = csr_pkg::CSR_MIN_PERIOD_CYC,
  parameter int MISS_GAP = csr_pkg::CSR_MISS_CYC,
  parameter int AUX_DIV  = 16
) (
  input  wire logic pclk,
  input  wire logic presetn,
  csr_clk_if.filt   cif
);
  typedef struct packed {
    logic [7:0] gap;
    logic [7:0] aux_cnt;
    logic       aux;
    logic       tick;
  } csr_sg_state_t;
  csr_sg_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.gap != 8'hff) begin
      nxt_st.gap = st_ff.gap + 8'h01;
    end
    if (!cif.safeguard_en) begin // R03
      nxt_st.aux  = 1'b0;
      nxt_st.tick = cif.osc_tick && !cif.main_osc_off;
    end else if (cif.osc_tick && !cif.main_osc_off) begin
      nxt_st.aux = 1'b0; // R19
      if (st_ff.gap >= 8'(MIN_GAP - 1)) begin // R01 R02
        nxt_st.tick = 1'b1;
        nxt_st.gap  = 8'h00;
      end
    end else if (cif.main_osc_off || st_ff.gap >= 8'(MISS_GAP)) begin
      nxt_st.aux = 1'b1; // R04 R18
    end
    if (st_ff.aux && cif.safeguard_en) begin
      nxt_st.aux_cnt = st_ff.aux_cnt + 8'h01;
      if (st_ff.aux_cnt == 8'(AUX_DIV - 1)) begin
        nxt_st.aux_cnt = 8'h00;
        nxt_st.tick    = 1'b1;
      end
    end else begin
      nxt_st.aux_cnt = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.clk_tick   = st_ff.tick;
  assign cif.aux_active = st_ff.aux;

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.safeguard_en && st_ff.tick && !st_ff.aux) |=> !st_ff.tick) // R02
    else $error("safeguard ticks too close");
  a_aux_start: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.safeguard_en && cif.main_osc_off) |=> st_ff.aux) // R18
    else $error("aux oscillator did not start");
endmodule : csr_safeguard

/* test/clock_safeguard_reset_control_tb.sv */
`timescale 1ns/1ps
module clock_safeguard_reset_control_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, osc, pin, oe, rst, pu, wdr, run, go, nmi, tk, aux;
  logic        pull = 1'b0, por = 1'b0, wdt = 1'b0, low_voltage_detector = 1'b0;
  logic        sg = 1'b1;
  logic [31:0] div_img = 32'h0000_0000;
  logic [11:0] pc;
  logic [1:0]  mode = 2'd0;
  int          err_total = 0, check_count = 0, cyc = 0, n, i;

  csr_osc_model mdl (.pclk(pclk), .mode(mode), .pull_low(pull), .dev_oe(oe),
    .osc_tick(osc), .pin_level(pin));
  csr_clock_reset #(.STAB_CYC(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .osc_in_tick(osc),
    .safeguard_option(sg), .reset_pin_in(pin), .reset_pin_out(), .reset_pin_oe(oe),
    .power_on_det(por), .watchdog_timeout(wdt), .low_voltage_det(low_voltage_detector),
    .stop_mode(1'b0), .int_clk_tick(tk), .aux_osc_active(aux), .core_reset(rst),
    .io_pullup_inputs(pu), .watchdog_reinit(wdr), .main_osc_run(run),
    .init_start(go), .init_pc(pc), .init_nmi_mode(nmi));

  initial begin
    forever #25 pclk = ~pclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_init;
    for (i = 0; i < 600 && go !== 1'b1; i++) @(posedge pclk);
    chk("init", 32'(go), 1);
    chk("pc", 32'(pc), 32'h0000_0ffe);
    chk("nmi", 32'(nmi), 1);
    @(posedge pclk);
    chk("rst", 32'(rst), 0);
  endtask : wait_init
  task results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ==========================================
  // Sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_init();
    $display("test init done");
    for (int s = 0; s < 4; s++) begin
      div_img = 32'(s);
      apb(1, 12'h0dc, div_img);
      apb(0, 12'h0d4, 0);
      chk("div", 32'(rd[1:0]), div_img);
      apb(0, 12'h0dc, 0);
      chk("wo", rd, 0);
    end
    apb(0, 12'h0e0, 0);
    chk("slverr", 32'(er), 1);
    n = 0;
    repeat (80) begin
      @(posedge pclk);
      n += tk;
    end
    chk("div4", 32'(n >= 9 && n <= 11), 1);
    apb(1, 12'h0dc, 0);
    mode <= 2'd2;
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      n += tk;
    end
    chk("spike", 32'(n >= 18 && n <= 20), 1);
    mode <= 2'd1;
    for (i = 0; i < 64 && aux !== 1'b1; i++) @(posedge pclk);
    chk("aux", 32'(aux), 1);
    mode <= 2'd0;
    for (i = 0; i < 64 && aux !== 1'b0; i++) @(posedge pclk);
    chk("aux off", 32'(aux), 0);
    apb(1, 12'h0d0, 32'h0000_0004);
    for (i = 0; i < 64 && aux !== 1'b1; i++) @(posedge pclk);
    chk("osc off", 32'(run), 0);
    chk("aux on", 32'(aux), 1);
    $display("test clock done");
    for (int k = 0; k < 4; k++) begin
      apb(1, 12'h0dc, 1);
      pull <= (k == 0);
      por  <= (k == 1);
      wdt  <= (k == 2);
      low_voltage_detector  <= (k == 3);
      repeat (4) @(posedge pclk);
      chk("rst", 32'(rst), 1);
      chk("pullup", 32'(pu), 1);
      chk("run", 32'(run), 1);
      chk("pin oe", 32'(oe), 32'(k != 0));
      chk("wd", 32'(wdr), 32'(k == 2));
      pull <= 1'b0;
      por  <= 1'b0;
      wdt  <= 1'b0;
      low_voltage_detector  <= 1'b0;
      wait_init();
      apb(0, 12'h0d4, 0);
      chk("cleared", 32'(rd[1:0]), 0);
    end
    $display("test resets done");
    // Safeguard off, as for serial or precise-timing designs
    sg <= 1'b0;
    apb(1, 12'h0d0, 32'h0000_0004);
    chk("osc off ignored", 32'(run), 1);
    mode <= 2'd1;
    repeat (24) @(posedge pclk);
    chk("no aux", 32'(aux), 0);
    mode <= 2'd0;
    sg   <= 1'b1;
    repeat (4) @(posedge pclk);
    $display("test option done");
    results();
  end
endmodule : clock_safeguard_reset_control_tb

/* test/csr_osc_model.sv */
`timescale 1ns/1ps
module csr_osc_model (
  input  wire logic       pclk,
  input  wire logic [1:0] mode,
  input  wire logic       pull_low,
  input  wire logic       dev_oe,
  output logic            osc_tick,
  output logic            pin_level
);
  logic ph_ff = 1'b0;
  // ==========================================
  // Reset wire: pull-up, either party pulls low
  assign pin_level = !(pull_low || dev_oe);
  // ==========================================
  // Oscillator: 0 nominal, 1 dead, 2 spiking
  initial osc_tick = 1'b0;
  always @(posedge pclk) begin
    ph_ff    <= !ph_ff;
    osc_tick <= (mode == 2'd2) || (mode == 2'd0 && ph_ff);
  end
endmodule : csr_osc_model
